// File: hw/return_rotate_exec.sv
`timescale 1ns/1ps
// Overview of operation
// - Software reset op pulses a full device reset and clears the soft reset flag.
// - Return from interrupt pops the stack and loads top of stack into PC; 2 cycles.
// - Return from interrupt also sets the global interrupt enable bit, bit 7.
// - Return pops the stack into PC, touches no flags, takes 2 cycles.
// - Return with literal writes the 8-bit literal to W and reloads PC; 2 cycles.
// - Rotate left: old carry into bit 0, old bit 7 to carry; 1 cycle.
// - Rotate right: old carry into bit 7, old bit 0 to carry.
// - Rotate file address 0 to 127; destination 0 writes W, 1 writes file.
module return_rotate_exec
(
    input wire logic CLK, // 25 MHz instruction clock
    input wire logic SYS_RST, // Synchronous reset, active high
    input wire logic OP_VALID, // Operation offered this cycle
    output logic OP_READY, // Operation can be taken this cycle
    input wire return_rotate_pkg::op_t OP_CODE, // Operation to execute
    input wire logic [return_rotate_pkg::DATA_W-1:0] OP_LITERAL, // Literal operand
    input wire logic [return_rotate_pkg::FADDR_W-1:0] OP_FILE_ADDR, // Rotate file address
    input wire logic OP_DEST, // Rotate destination select
    input wire logic [return_rotate_pkg::DATA_W-1:0] FILE_RDATA, // Addressed file register
    input wire logic CARRY_IN, // Current carry flag
    input wire logic [return_rotate_pkg::PC_W-1:0] TOP_OF_STACK, // Stack top value
    output logic STACK_POP, // Pop the hardware stack
    output logic PC_LOAD, // Load the program counter
    output logic [return_rotate_pkg::PC_W-1:0] PC_VALUE, // New program counter
    output logic W_WE, // Write the working register
    output logic [return_rotate_pkg::DATA_W-1:0] W_DATA, // Working register data
    output logic FILE_WE, // Write the file register
    output logic [return_rotate_pkg::FADDR_W-1:0] FILE_ADDR, // File register address
    output logic [return_rotate_pkg::DATA_W-1:0] FILE_WDATA, // File register data
    output logic CARRY_WE, // Write the carry flag
    output logic CARRY_OUT, // New carry flag
    output logic GLOBAL_INTERRUPT_ENABLE_SET, // Set the global interrupt enable bit
    output logic DEVICE_RESET, // Request a full device reset
    output logic SOFT_RESET_FLAG_N_CLR // Clear the soft reset flag
);
    import return_rotate_pkg::*;

    state_t state_r;
    state_t state_nxt;
    logic stack_pop_r;
    logic pc_load_r;
    logic [PC_W-1:0] pc_value_r;
    logic w_we_r;
    logic [DATA_W-1:0] w_data_r;
    logic file_we_r;
    logic [FADDR_W-1:0] file_addr_r;
    logic [DATA_W-1:0] file_wdata_r;
    logic carry_we_r;
    logic carry_out_r;
    logic int_enable_set_r;
    logic device_reset_r;
    logic flag_clr_r;

    wire take = OP_VALID && OP_READY;
    wire is_soft_reset = take && (OP_CODE == OP_SOFT_RESET);
    wire is_reti = take && (OP_CODE == OP_RETURN_FROM_INTERRUPT);
    wire is_ret = take && (OP_CODE == OP_RETURN);
    wire is_lit_ret = take && (OP_CODE == OP_RETURN_WITH_LITERAL);
    wire is_rol = take && (OP_CODE == OP_ROTATE_LEFT);
    wire is_ror = take && (OP_CODE == OP_ROTATE_RIGHT);
    wire is_any_ret = is_reti || is_ret || is_lit_ret;
    wire is_rot = is_rol || is_ror;

    // Rotate results through carry.
    wire [DATA_W-1:0] rol_data = {FILE_RDATA[DATA_W-2:0], CARRY_IN};
    wire rol_carry = FILE_RDATA[DATA_W-1];
    wire [DATA_W-1:0] ror_data = {CARRY_IN, FILE_RDATA[DATA_W-1:1]};
    wire ror_carry = FILE_RDATA[0];
    wire [DATA_W-1:0] rot_data = is_rol ? rol_data : ror_data;
    wire rot_carry = is_rol ? rol_carry : ror_carry;

    // Returns occupy a second cycle in which no new operation is taken.
    assign OP_READY = (state_r == ST_IDLE);
    assign state_nxt = (is_any_ret) ? ST_SECOND : ST_IDLE;

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state_r <= ST_IDLE;
            stack_pop_r <= 1'b0;
            pc_load_r <= 1'b0;
            pc_value_r <= PC_RST;
            int_enable_set_r <= 1'b0;
            device_reset_r <= 1'b0;
            flag_clr_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            stack_pop_r <= is_any_ret;
            pc_load_r <= is_any_ret;
            if (is_any_ret)
            begin
                pc_value_r <= TOP_OF_STACK;
            end
            int_enable_set_r <= is_reti;
            device_reset_r <= is_soft_reset;
            flag_clr_r <= is_soft_reset;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            w_we_r <= 1'b0;
            w_data_r <= DATA_RST;
            file_we_r <= 1'b0;
            file_addr_r <= FADDR_RST;
            file_wdata_r <= DATA_RST;
            carry_we_r <= 1'b0;
            carry_out_r <= 1'b0;
        end
        else
        begin
            w_we_r <= is_lit_ret || (is_rot && OP_DEST == DEST_WREG);
            if (is_lit_ret)
            begin
                w_data_r <= OP_LITERAL;
            end
            else if (is_rot)
            begin
                w_data_r <= rot_data;
            end
            file_we_r <= is_rot && (OP_DEST == DEST_FILE);
            if (is_rot)
            begin
                file_addr_r <= OP_FILE_ADDR;
                file_wdata_r <= rot_data;
                carry_out_r <= rot_carry;
            end
            carry_we_r <= is_rot;
        end
    end

    assign STACK_POP = stack_pop_r;
    assign PC_LOAD = pc_load_r;
    assign PC_VALUE = pc_value_r;
    assign W_WE = w_we_r;
    assign W_DATA = w_data_r;
    assign FILE_WE = file_we_r;
    assign FILE_ADDR = file_addr_r;
    assign FILE_WDATA = file_wdata_r;
    assign CARRY_WE = carry_we_r;
    assign CARRY_OUT = carry_out_r;
    assign GLOBAL_INTERRUPT_ENABLE_SET = int_enable_set_r;
    assign DEVICE_RESET = device_reset_r;
    assign SOFT_RESET_FLAG_N_CLR = flag_clr_r;

    a_soft_reset_pulse: assert property (@(posedge CLK) disable iff (SYS_RST)
        OP_VALID && OP_READY && OP_CODE == OP_SOFT_RESET |=> DEVICE_RESET && SOFT_RESET_FLAG_N_CLR)
        else $error("Software reset did not raise reset and flag clear.");

    a_reti_two_cycles: assert property (@(posedge CLK) disable iff (SYS_RST)
        OP_VALID && OP_READY && OP_CODE == OP_RETURN_FROM_INTERRUPT
        |=> PC_LOAD && STACK_POP && !OP_READY ##1 OP_READY && !PC_LOAD)
        else $error("Return from interrupt did not take two cycles with one pop.");

    a_enable_set_cause: assert property (@(posedge CLK) disable iff (SYS_RST)
        GLOBAL_INTERRUPT_ENABLE_SET
        |-> PC_LOAD && $past(OP_CODE) == OP_RETURN_FROM_INTERRUPT)
        else $error("Interrupt enable set outside return from interrupt.");

    a_interrupt_enable_set: assert property (@(posedge CLK) disable iff (SYS_RST)
        OP_VALID && OP_READY && OP_CODE == OP_RETURN_FROM_INTERRUPT
        |=> GLOBAL_INTERRUPT_ENABLE_SET)
        else $error("Return from interrupt did not set the interrupt enable.");

    a_return_loads_top: assert property (@(posedge CLK) disable iff (SYS_RST)
        OP_VALID && OP_READY && OP_CODE == OP_RETURN
        |=> PC_VALUE == $past(TOP_OF_STACK) && !CARRY_WE && !W_WE
            && !GLOBAL_INTERRUPT_ENABLE_SET)
        else $error("Return loaded a wrong PC or touched flags.");

    a_literal_return: assert property (@(posedge CLK) disable iff (SYS_RST)
        OP_VALID && OP_READY && OP_CODE == OP_RETURN_WITH_LITERAL
        |=> W_WE && W_DATA == $past(OP_LITERAL) && PC_LOAD && !CARRY_WE)
        else $error("Return with literal gave a wrong working register value.");

    a_rotate_left: assert property (@(posedge CLK) disable iff (SYS_RST)
        OP_VALID && OP_READY && OP_CODE == OP_ROTATE_LEFT
        |=> CARRY_OUT == $past(FILE_RDATA[7]) && W_DATA[0] == $past(CARRY_IN)
            && W_DATA[7:1] == $past(FILE_RDATA[6:0]) && OP_READY)
        else $error("Rotate left result is wrong.");

    a_rotate_right: assert property (@(posedge CLK) disable iff (SYS_RST)
        OP_VALID && OP_READY && OP_CODE == OP_ROTATE_RIGHT
        |=> CARRY_OUT == $past(FILE_RDATA[0]) && FILE_WDATA[7] == $past(CARRY_IN)
            && FILE_WDATA[6:0] == $past(FILE_RDATA[7:1]))
        else $error("Rotate right result is wrong.");

    a_rotate_dest: assert property (@(posedge CLK) disable iff (SYS_RST)
        OP_VALID && OP_READY && (OP_CODE == OP_ROTATE_LEFT || OP_CODE == OP_ROTATE_RIGHT)
        |=> FILE_WE == $past(OP_DEST) && W_WE == !$past(OP_DEST)
            && FILE_ADDR == $past(OP_FILE_ADDR))
        else $error("Rotate result went to the wrong destination.");

    a_rotate_flags_only: assert property (@(posedge CLK) disable iff (SYS_RST)
        CARRY_WE |-> !PC_LOAD && (FILE_WE != W_WE))
        else $error("Rotate changed more than the carry and one destination.");

    // An offer held through the busy cycle of a return must leave no trace at that edge.
    a_busy_refuses: assert property (@(posedge CLK) disable iff (SYS_RST)
        !OP_READY |=> !STACK_POP && !PC_LOAD && !CARRY_WE && !W_WE && !DEVICE_RESET)
        else $error("An operation was taken in the busy cycle of a return.");

    a_pop_one_cycle: assert property (@(posedge CLK) disable iff (SYS_RST)
        STACK_POP |=> !STACK_POP)
        else $error("The stack was popped twice by one return.");

    a_return_pops: assert property (@(posedge CLK) disable iff (SYS_RST)
        OP_VALID && OP_READY && OP_CODE == OP_RETURN
        |=> STACK_POP && PC_LOAD && !OP_READY ##1 OP_READY)
        else $error("Return did not pop the stack over two cycles.");

    // The device reset request carries no other register write with it.
    a_soft_reset_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
        DEVICE_RESET |-> !PC_LOAD && !W_WE && !FILE_WE && !CARRY_WE)
        else $error("Software reset wrote a register besides requesting reset.");

endmodule // return_rotate_exec

// File: hw/return_rotate_pkg.sv
package return_rotate_pkg;

    localparam int DATA_W = 8;
    localparam int PC_W = 15;
    localparam int FADDR_W = 7;

    // Position of the global interrupt enable bit in the interrupt control register.
    localparam int GLOBAL_INTERRUPT_ENABLE_BIT = 7;

    // Instruction cycles taken by each group of operations.
    localparam int RET_CYCLES = 2;
    localparam int ROT_CYCLES = 1;

    // Reset values of the registered outputs.
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 15'h0000;
    localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;

    // Destination select of the rotate operations.
    localparam logic DEST_WREG = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // Operation handed over by the fetch and decode logic.
    typedef enum logic [2:0] {
        OP_SOFT_RESET = 3'h0,
        OP_RETURN_FROM_INTERRUPT = 3'h1,
        OP_RETURN = 3'h2,
        OP_RETURN_WITH_LITERAL = 3'h3,
        OP_ROTATE_LEFT = 3'h4,
        OP_ROTATE_RIGHT = 3'h5
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SECOND = 2'b10
    } state_t;

endpackage

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import return_rotate_pkg::*;
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic OP_VALID = 1'b0;
    op_t OP_CODE = OP_RETURN;
    logic [DATA_W-1:0] OP_LITERAL = 8'h00;
    logic [FADDR_W-1:0] OP_FILE_ADDR = 7'h00;
    logic OP_DEST = 1'b0;
    logic [DATA_W-1:0] FILE_RDATA = 8'h00;
    logic CARRY_IN = 1'b0;
    logic [PC_W-1:0] TOP_OF_STACK = 15'h0000;
    logic OP_READY, STACK_POP, PC_LOAD, W_WE, FILE_WE, CARRY_WE, CARRY_OUT;
    logic DEVICE_RESET, SOFT_RESET_FLAG_N_CLR, GLOBAL_INTERRUPT_ENABLE_SET;
    logic [PC_W-1:0] PC_VALUE;
    logic [DATA_W-1:0] W_DATA, FILE_WDATA;
    logic [FADDR_W-1:0] FILE_ADDR;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;

    return_rotate_exec u_dut (.CLK, .SYS_RST, .OP_VALID, .OP_READY, .OP_CODE, .OP_LITERAL,
        .OP_FILE_ADDR, .OP_DEST, .FILE_RDATA, .CARRY_IN, .TOP_OF_STACK, .STACK_POP, .PC_LOAD,
        .PC_VALUE, .W_WE, .W_DATA, .FILE_WE, .FILE_ADDR, .FILE_WDATA, .CARRY_WE, .CARRY_OUT,
        .GLOBAL_INTERRUPT_ENABLE_SET, .DEVICE_RESET, .SOFT_RESET_FLAG_N_CLR);

    initial
    begin
        forever #20 CLK = ~CLK;
    end

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Offers one operation and returns in the middle of the cycle after the take.
    task automatic op(input op_t c, input logic [7:0] k, input logic [6:0] fa, input logic d,
        input logic [7:0] fr, input logic ci, input logic [14:0] top);
        @(negedge CLK);
        OP_CODE = c;
        {OP_LITERAL, OP_FILE_ADDR, OP_DEST, FILE_RDATA, CARRY_IN} = {k, fa, d, fr, ci};
        TOP_OF_STACK = top;
        OP_VALID = 1'b1;
        @(negedge CLK);
        OP_VALID = 1'b0;
    endtask

    task automatic t_soft_reset;
        op(OP_SOFT_RESET, 8'h00, 7'h00, 1'b0, 8'h00, 1'b0, 15'h0000);
        chk("DEVICE_RESET", 16'(DEVICE_RESET), 16'h1);
        chk("SOFT_RESET_FLAG_N_CLR", 16'(SOFT_RESET_FLAG_N_CLR), 16'h1);
        chk("PC_LOAD", 16'(PC_LOAD), 16'h0);
    endtask

    // Checks the second cycle of a return and the cycle after it; the second cycle must refuse a new offer.
    task automatic ret_chk(input logic [14:0] top, input logic int_en, input logic [7:0] k,
        input logic wwe);
        chk("STACK_POP", 16'(STACK_POP), 16'h1);
        chk("PC_VALUE", 16'(PC_VALUE & {PC_W{PC_LOAD}}), 16'(top));
        chk("GLOBAL_INTERRUPT_ENABLE_SET", 16'(GLOBAL_INTERRUPT_ENABLE_SET), 16'(int_en));
        chk("CARRY_WE", 16'(CARRY_WE), 16'h0);
        chk("W_WE", 16'(W_WE), 16'(wwe));
        if (wwe)
            chk("W_DATA", 16'(W_DATA), 16'(k));
        chk("OP_READY busy", 16'(OP_READY), 16'h0);
        @(negedge CLK);
        chk("pulses done", 16'({STACK_POP, PC_LOAD, GLOBAL_INTERRUPT_ENABLE_SET, W_WE}),
            16'h0);
        chk("OP_READY free", 16'(OP_READY), 16'h1);
    endtask

    task automatic t_return_from_interrupt;
        op(OP_RETURN_FROM_INTERRUPT, 8'h00, 7'h00, 1'b0, 8'h00, 1'b1, 15'h7fff);
        ret_chk(15'h7fff, 1'b1, 8'h00, 1'b0);
    endtask

    task automatic t_return;
        op(OP_RETURN, 8'h00, 7'h00, 1'b0, 8'h00, 1'b1, 15'h2a55);
        ret_chk(15'h2a55, 1'b0, 8'h00, 1'b0);
    endtask

    task automatic t_return_with_literal(input logic [7:0] k);
        op(OP_RETURN_WITH_LITERAL, k, 7'h00, 1'b0, 8'h00, 1'b0, 15'h0123);
        ret_chk(15'h0123, 1'b0, k, 1'b1);
    endtask

    // Rotates through carry and checks the destination, the carry and the single cycle.
    task automatic t_rotate(input logic l, input logic d, input logic [6:0] fa,
        input logic [7:0] fr, input logic ci);
        logic [7:0] r;
        logic c;
        r = l ? {fr[6:0], ci} : {ci, fr[7:1]};
        c = l ? fr[7] : fr[0];
        op(op_t'(l ? OP_ROTATE_LEFT : OP_ROTATE_RIGHT), 8'h00, fa, d, fr, ci, 15'h0000);
        chk("CARRY_WE", 16'(CARRY_WE), 16'h1);
        chk("CARRY_OUT", 16'(CARRY_OUT), 16'(c));
        chk("W_WE", 16'(W_WE), 16'(!d));
        chk("FILE_WE", 16'(FILE_WE), 16'(d));
        chk("result", 16'(d ? FILE_WDATA : W_DATA), 16'(r));
        if (d)
            chk("FILE_ADDR", 16'(FILE_ADDR), 16'(fa));
        chk("OP_READY", 16'(OP_READY), 16'h1);
    endtask

    // A rotate offered in the busy cycle of a return is held and must be taken one cycle later.
    task automatic t_held_offer;
        @(negedge CLK);
        OP_CODE = OP_RETURN;
        TOP_OF_STACK = 15'h1234;
        OP_VALID = 1'b1;
        @(negedge CLK);
        OP_CODE = OP_ROTATE_LEFT;
        FILE_RDATA = 8'h01;
        CARRY_IN = 1'b0;
        OP_DEST = DEST_FILE;
        @(negedge CLK);
        chk("held offer refused", 16'({CARRY_WE, STACK_POP}), 16'h0);
        @(negedge CLK);
        OP_VALID = 1'b0;
        chk("held offer taken", 16'({CARRY_WE, FILE_WE, CARRY_OUT, FILE_WDATA}),
            16'h602);
    endtask

    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            fails++;
            end_sim();
        end
    end

    initial
    begin
        repeat (12) @(negedge CLK);
        SYS_RST = 1'b0;
        chk("OP_READY reset", 16'(OP_READY), 16'h1);
        chk("DEVICE_RESET reset", 16'(DEVICE_RESET), 16'h0);
        t_rotate(1'b1, 1'b0, 7'h05, 8'he6, 1'b0);
        t_rotate(1'b1, 1'b1, 7'h7f, 8'h81, 1'b1);
        t_rotate(1'b0, 1'b1, 7'h00, 8'h81, 1'b0);
        t_rotate(1'b0, 1'b0, 7'h40, 8'h01, 1'b1);
        t_return_from_interrupt();
        t_return();
        t_return_with_literal(8'h00);
        t_return_with_literal(8'hff);
        t_held_offer();
        t_soft_reset();
        end_sim();
    end
endmodule // tb_top
